/* File: adcc_regs.svh */
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
// APB address width and register byte addresses.
`define ADCC_AW 12
`define ADCC_CTRL_ADDR 12'h000
`define ADCC_STATUS_ADDR 12'h004
`define ADCC_SAMPLE_ADDR 12'h008
`define ADCC_COUNT_ADDR 12'h00C
// Control register layout and reset value.
`define ADCC_CTRL_W 4
`define ADCC_CTRL_RESET 4'h0
`define ADCC_PD_BIT 0
`define ADCC_OEN_BIT 1
`define ADCC_MODE_LSB 2
`define ADCC_MODE_MSB 3
// Status register layout.
`define ADCC_ST_OP_LSB 0
`define ADCC_ST_OP_MSB 1
`define ADCC_ST_TWOS_BIT 2
`define ADCC_ST_STAB_BIT 3
`define ADCC_ST_FLAG_BIT 4
// Sample register layout and capture counter width.
`define ADCC_SMP_FLAG_BIT 11
`define ADCC_CNT_W 16
// Word width, input width and conversion limits.
`define ADCC_W 11
`define ADCC_MSB 10
`define ADCC_IN_W 13
`define ADCC_IN_MAX 13'sh03FF
`define ADCC_IN_MIN 13'sh1C00
`define ADCC_CODE_TOP 11'h7FF
// Bits resolved by each of the five pipeline stages.
`define ADCC_MASK_S1 11'h700
`define ADCC_MASK_S2 11'h0C0
`define ADCC_MASK_S3 11'h030
`define ADCC_MASK_S4 11'h00C
`define ADCC_MASK_S5 11'h003
`endif

/* File: adcc_pkg.sv */
package adcc_pkg;
`include "adcc_regs.svh"
    // Operating modes picked by the power-down select and output enable.
    typedef enum logic [1:0] {OP_NORMAL, OP_OUT_OFF, OP_NAP, OP_SLEEP} adcc_op_e;
    // Output format and stabiliser settings, in order of the mode level.
    typedef enum logic [1:0] {FMT_OB_STAB_OFF, FMT_OB_STAB_ON, FMT_TC_STAB_ON, FMT_TC_STAB_OFF} adcc_fmt_e;
    // One pipeline stage: bits resolved so far, the residue left, range flag.
    typedef struct packed {
        logic [`ADCC_W-1:0] code;
        logic [`ADCC_W-1:0] res;
        logic ovr;
    } adcc_stage_s;
    // State clocked on the rising encode edge.
    typedef struct packed {
        logic [1:0] rstSync;
        logic [`ADCC_CTRL_W-1:0] ctrlMeta;
        logic [`ADCC_CTRL_W-1:0] ctrlSync;
        adcc_op_e op;
        adcc_fmt_e fmt;
        logic run;
        adcc_stage_s held;
        adcc_stage_s s2;
        adcc_stage_s s4;
        adcc_stage_s a1;
        adcc_stage_s a2;
        logic [`ADCC_W-1:0] word;
        logic flag;
        logic oe;
        logic posTog;
        logic req;
        logic [`ADCC_W-1:0] snapWord;
        logic snapFlag;
        logic ackMeta;
        logic ackSync;
    } adcc_encp_s;
    // State clocked on the falling encode edge.
    typedef struct packed {
        adcc_stage_s s1;
        adcc_stage_s s3;
        adcc_stage_s s5;
        logic negTog;
    } adcc_encn_s;
    // State clocked on the core clock.
    typedef struct packed {
        logic [`ADCC_CTRL_W-1:0] ctrl;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic reqMeta;
        logic reqSync;
        logic ack;
        logic [`ADCC_W-1:0] lastWord;
        logic lastFlag;
        logic [`ADCC_CNT_W-1:0] count;
    } adcc_core_s;
endpackage : adcc_pkg

/* File: adcc_top.sv */
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Operation
// - Encode high when positive exceeds complement.
// - Input is tracked while encode is low.
// - Rising encode edge freezes the tracked sample.
// - Five stages alternate on opposite encode phases.
// - Word appears five encode cycles after sampling.
// - Stage results aligned and merged before output.
// - Normal mode converts and drives outputs.
// - Output-disabled mode converts, outputs high impedance.
// - Nap mode: outputs high impedance.
// - Sleep mode: outputs high impedance.
// - Mode selects format and stabiliser.
// - Eleven-bit word, top bit is MSB.
// - Range flag high for out-of-range samples.
// - Sampling-to-output delay is exactly five cycles.
module adcc_top
    import adcc_pkg::*;
(
    // System clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADCC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encode clock pair and digitised analog input.
    input wire logic encodeClockPos,
    input wire logic encodeClockNeg,
    input wire logic signed [`ADCC_IN_W-1:0] analogInput,
    // Converter outputs towards the capture logic.
    output logic [`ADCC_W-1:0] sampleWord,
    output logic sampleWordOe,
    output logic rangeExceededFlag,
    output logic dataValidClock
);

    adcc_core_s c; // Core-clock state.
    adcc_core_s cd; // Next core-clock state.
    adcc_encp_s p; // Rising-edge encode state.
    adcc_encp_s pd; // Next rising-edge encode state.
    adcc_encn_s n; // Falling-edge encode state.
    adcc_encn_s nd; // Next falling-edge encode state.
    logic encClk; // Internal encode clock after the comparator.
    logic encRst; // Reset as seen in the encode domain.

    // Decodes the two static pins into an operating mode.
    function automatic adcc_op_e opDecode(input logic pd_, input logic oeN);
        adcc_op_e op;
        case ({pd_, oeN})
            2'b00: op = OP_NORMAL;
            2'b01: op = OP_OUT_OFF;
            2'b10: op = OP_NAP;
            default: op = OP_SLEEP;
        endcase
        return op;
    endfunction : opDecode

    // True when the format setting turns the duty-cycle stabiliser on.
    function automatic logic stabOn(input adcc_fmt_e f);
        return (f == FMT_OB_STAB_ON) || (f == FMT_TC_STAB_ON);
    endfunction : stabOn

    // True when the format setting asks for two's complement.
    function automatic logic twosOn(input adcc_fmt_e f);
        return (f == FMT_TC_STAB_ON) || (f == FMT_TC_STAB_OFF);
    endfunction : twosOn

    // Turns the internal offset-binary code into the selected format.
    function automatic logic [`ADCC_W-1:0] formatWord(input logic [`ADCC_W-1:0] code, input adcc_fmt_e f);
        logic [`ADCC_W-1:0] w;
        w = code;
        if (twosOn(f)) begin
            w[`ADCC_MSB] = ~code[`ADCC_MSB];
        end
        return w;
    endfunction : formatWord

    // One pipeline stage resolves its own bits and passes the residue on.
    function automatic adcc_stage_s stageStep(input adcc_stage_s in, input logic [`ADCC_W-1:0] mask);
        adcc_stage_s o;
        o.code = in.code | (in.res & mask);
        o.res = in.res & ~mask;
        o.ovr = in.ovr;
        return o;
    endfunction : stageStep

    // Clamps the held input to the code range and flags the excess.
    function automatic adcc_stage_s sampleOf(input logic signed [`ADCC_IN_W-1:0] x);
        adcc_stage_s s;
        s.code = '0;
        if (x > `ADCC_IN_MAX) begin
            s.res = `ADCC_CODE_TOP;
            s.ovr = 1'b1;
        end else if (x < `ADCC_IN_MIN) begin
            s.res = '0;
            s.ovr = 1'b1;
        end else begin
            s.res = {~x[`ADCC_MSB], x[`ADCC_MSB-1:0]};
            s.ovr = 1'b0;
        end
        return s;
    endfunction : sampleOf

    // The differential pair is reduced to one clock: high only when the
    // positive input wins, so equal levels count as low.
    assign encClk = encodeClockPos & ~encodeClockNeg;
    assign encRst = p.rstSync[1];

    // Pin outputs come straight from encode-domain flip-flops.
    assign sampleWord = p.word;
    assign sampleWordOe = p.oe;
    assign rangeExceededFlag = p.flag;
    // The data-valid clock is high from each rising edge to the next
    // falling edge; the two toggles keep it in phase with encode without
    // gating a clock, at the cost of one XOR after the flip-flops.
    assign dataValidClock = p.posTog ^ n.negTog;
    // APB outputs are registered.
    assign prdata = c.rdata;
    assign pready = c.ready;
    assign pslverr = c.slverr;

    // Rising-edge encode logic: sampling, even stages, alignment, output.
    always_comb begin
        pd = p;
        // Control bits are static straps in practice, so a plain two-stage
        // synchroniser per bit is enough; a change may take an extra cycle.
        pd.ctrlMeta = c.ctrl;
        pd.ctrlSync = p.ctrlMeta;
        pd.ackMeta = c.ack;
        pd.ackSync = p.ackMeta;
        pd.op = opDecode(p.ctrlSync[`ADCC_PD_BIT], p.ctrlSync[`ADCC_OEN_BIT]);
        pd.fmt = adcc_fmt_e'(p.ctrlSync[`ADCC_MODE_MSB:`ADCC_MODE_LSB]);
        // Conversion runs in normal and output-disabled modes only.
        pd.run = (p.op == OP_NORMAL) || (p.op == OP_OUT_OFF);
        pd.oe = (p.op == OP_NORMAL);
        pd.posTog = ~p.posTog;
        if (p.run) begin
            // The input is followed while encode is low; the value present
            // at the rising edge is the one that is frozen.
            pd.held = sampleOf(analogInput);
            pd.s2 = stageStep(n.s1, `ADCC_MASK_S2);
            pd.s4 = stageStep(n.s3, `ADCC_MASK_S4);
            // Two alignment registers bring every sample to the same
            // fixed delay before the merged word leaves.
            pd.a1 = n.s5;
            pd.a2 = p.a1;
            pd.word = formatWord(p.a2.code, p.fmt);
            pd.flag = p.a2.ovr;
            // Only hand a new snapshot over once the last was taken.
            if (p.req == p.ackSync) begin
                pd.snapWord = pd.word;
                pd.snapFlag = pd.flag;
                pd.req = ~p.req;
            end
        end else if (p.op == OP_SLEEP) begin
            // Sleep drops the pipeline; nap merely holds it.
            pd.held = '0;
            pd.s2 = '0;
            pd.s4 = '0;
            pd.a1 = '0;
            pd.a2 = '0;
        end
        if (encRst) begin
            pd = '0;
        end
        pd.rstSync = {p.rstSync[0], rst};
    end

    // Registers the rising-edge encode state.
    always_ff @(posedge encClk) begin
        p <= pd;
    end

    // Falling-edge encode logic: the odd stages work on the other phase.
    always_comb begin
        nd = n;
        nd.negTog = p.posTog;
        if (p.run) begin
            nd.s1 = stageStep(p.held, `ADCC_MASK_S1);
            nd.s3 = stageStep(p.s2, `ADCC_MASK_S3);
            nd.s5 = stageStep(p.s4, `ADCC_MASK_S5);
        end else if (p.op == OP_SLEEP) begin
            nd.s1 = '0;
            nd.s3 = '0;
            nd.s5 = '0;
        end
        if (encRst) begin
            nd = '0;
        end
    end

    // Registers the falling-edge encode state.
    always_ff @(negedge encClk) begin
        n <= nd;
    end

    // Core logic: APB slave, control register, snapshot capture.
    always_comb begin
        cd = c;
        cd.reqMeta = p.req;
        cd.reqSync = c.reqMeta;
        // Zero wait states: ready is raised for the access cycle.
        cd.ready = psel && !penable;
        cd.slverr = 1'b0;
        if (psel && !penable) begin
            cd.rdata = '0;
            case (paddr)
                `ADCC_CTRL_ADDR: begin
                    cd.rdata[`ADCC_CTRL_W-1:0] = c.ctrl;
                end
                `ADCC_STATUS_ADDR: begin
                    cd.rdata[`ADCC_ST_OP_MSB:`ADCC_ST_OP_LSB] =
                        opDecode(c.ctrl[`ADCC_PD_BIT], c.ctrl[`ADCC_OEN_BIT]);
                    cd.rdata[`ADCC_ST_TWOS_BIT] = twosOn(adcc_fmt_e'(c.ctrl[`ADCC_MODE_MSB:`ADCC_MODE_LSB]));
                    cd.rdata[`ADCC_ST_STAB_BIT] = stabOn(adcc_fmt_e'(c.ctrl[`ADCC_MODE_MSB:`ADCC_MODE_LSB]));
                    cd.rdata[`ADCC_ST_FLAG_BIT] = c.lastFlag;
                end
                `ADCC_SAMPLE_ADDR: begin
                    cd.rdata[`ADCC_W-1:0] = c.lastWord;
                    cd.rdata[`ADCC_SMP_FLAG_BIT] = c.lastFlag;
                end
                `ADCC_COUNT_ADDR: begin
                    cd.rdata[`ADCC_CNT_W-1:0] = c.count;
                end
                default: begin
                    // Unmapped addresses answer with an error and zero data.
                    cd.slverr = 1'b1;
                end
            endcase
        end
        // Writes land on the access edge; other registers are read-only.
        if (psel && penable && pwrite && c.ready && (paddr == `ADCC_CTRL_ADDR)) begin
            cd.ctrl = pwdata[`ADCC_CTRL_W-1:0];
        end
        // The snapshot is stable while request and acknowledge differ.
        if (c.reqSync != c.ack) begin
            cd.lastWord = p.snapWord;
            cd.lastFlag = p.snapFlag;
            cd.count = c.count + 1'b1;
            cd.ack = ~c.ack;
        end
        if (rst) begin
            cd = '0;
            cd.ctrl = `ADCC_CTRL_RESET;
        end
    end

    // Registers the core state.
    always_ff @(posedge core_clk) begin
        c <= cd;
    end

    // Normal mode drives the outputs on the next edge.
    a_out_normal: assert property (@(posedge encClk) disable iff (encRst)
        (p.op == OP_NORMAL) |=> sampleWordOe)
        else $error("outputs not driven in normal mode");

    // Output-disabled mode keeps converting with outputs released.
    a_out_disabled: assert property (@(posedge encClk) disable iff (encRst)
        (p.op == OP_OUT_OFF) |=> (!sampleWordOe && p.run))
        else $error("output-disabled mode wrong");

    // Nap releases the outputs and holds the pipeline.
    a_nap_hold: assert property (@(posedge encClk) disable iff (encRst)
        (p.op == OP_NAP) ##1 (p.op == OP_NAP) |=> (!sampleWordOe && $stable(p.s2)))
        else $error("nap mode wrong");

    // Sleep releases the outputs and clears the pipeline.
    a_sleep_clear: assert property (@(posedge encClk) disable iff (encRst)
        (p.op == OP_SLEEP) |=> (!sampleWordOe && p.s2 == '0 && p.a2 == '0))
        else $error("sleep mode wrong");

    // The word leaves exactly five encode cycles after its sample.
    a_latency_five: assert property (@(posedge encClk) disable iff (encRst)
        p.run [*7] |-> (sampleWord == formatWord($past(p.held.res, 5), $past(p.fmt))))
        else $error("word latency is not five cycles");

    // The range flag travels with its own sample.
    a_range_delay: assert property (@(posedge encClk) disable iff (encRst)
        p.run [*7] |-> (rangeExceededFlag == $past(p.held.ovr, 5)))
        else $error("range flag misaligned");

    // An over-range input freezes as full scale with the flag set.
    a_freeze_over: assert property (@(posedge encClk) disable iff (encRst)
        (p.run && analogInput > `ADCC_IN_MAX) |=> (p.held.ovr && p.held.res == `ADCC_CODE_TOP))
        else $error("over-range sample not frozen");

    // The first stage takes its bits from the held sample half a cycle on.
    a_stage_half: assert property (@(negedge encClk) disable iff (encRst)
        $past(p.run) |-> (n.s1.code == ($past(p.held.res) & `ADCC_MASK_S1)))
        else $error("first stage out of phase");

    // Status shows the stabiliser setting of the control register.
    a_stab_status: assert property (@(posedge core_clk) disable iff (rst)
        (psel && !penable && paddr == `ADCC_STATUS_ADDR) |=>
        (prdata[`ADCC_ST_STAB_BIT] == stabOn(adcc_fmt_e'($past(c.ctrl[`ADCC_MODE_MSB:`ADCC_MODE_LSB])))))
        else $error("stabiliser status wrong");

    // The data-valid clock is low when encode rises, so it fell mid-word.
    a_dv_low_rise: assert property (@(posedge encClk) disable iff (encRst)
        $past(!encRst, 2) |-> !dataValidClock)
        else $error("data-valid clock out of phase");

    // Main scenarios worth seeing.
    c_nap_mode: cover property (@(posedge encClk) disable iff (encRst) p.op == OP_NAP);
    c_sleep_mode: cover property (@(posedge encClk) disable iff (encRst) p.op == OP_SLEEP);
    c_over_range: cover property (@(posedge encClk) disable iff (encRst) rangeExceededFlag && sampleWordOe);
    c_twos_word: cover property (@(posedge encClk) disable iff (encRst) sampleWordOe && twosOn(p.fmt));

endmodule : adcc_top

/* File: adcc_capture_model.sv */
`timescale 1ns/1ps
`include "adcc_regs.svh"
// Capture receiver that sits at the far side of the converter outputs.
module adcc_capture_model
    import adcc_pkg::*;
(
    // Converter outputs as seen on the board.
    input wire logic dataValidClock,
    input wire logic [`ADCC_W-1:0] sampleWord,
    input wire logic sampleWordOe,
    input wire logic rangeExceededFlag,
    // Latched results handed to the bench.
    output logic [`ADCC_W-1:0] capWord,
    output logic capFlag,
    output logic capOe,
    output logic [15:0] capCount
);
    // Last level the driven lines carried.
    logic [`ADCC_W:0] lastLine = '0;
    // Level on the lines, flag on top.
    logic [`ADCC_W:0] busLine;

    // A released bus has no pull, so it shows the inverse of its last value.
    // This keeps a floating bus from passing for a good word by luck.
    assign busLine = (sampleWordOe === 1'b1) ? {rangeExceededFlag, sampleWord} : ~lastLine;

    // Remember what the lines carried while they were driven.
    always @(sampleWordOe or sampleWord or rangeExceededFlag) begin
        if (sampleWordOe === 1'b1) begin
            lastLine = {rangeExceededFlag, sampleWord};
        end
    end

    // Clear the latched results at time zero.
    initial begin
        capWord = '0;
        capFlag = 1'b0;
        capOe = 1'b0;
        capCount = '0;
    end

    // Word and flag are latched on the falling edge of the data-valid clock.
    always @(negedge dataValidClock) begin
        capWord <= busLine[`ADCC_W-1:0];
        capFlag <= busLine[`ADCC_W];
        capOe <= sampleWordOe;
        capCount <= capCount + 16'h0001;
    end
endmodule : adcc_capture_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "adcc_regs.svh"
// Counts a comparison and reports a mismatch at once.
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin nFail++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
// Bench for the converter output control block.
module testbench;
    import adcc_pkg::*;
    // Expected converter word, due at a given encode edge count.
    typedef struct {int due; logic [`ADCC_W:0] val;} adcc_note_s;
    // Expected APB answer: data, mask of checked bits, error.
    typedef struct {logic [31:0] ex; logic [31:0] mk; logic er;} adcc_apb_s;
    // Clocks, reset and bus.
    logic core_clk = 1'b0;
    logic encClk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`ADCC_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Converter side.
    logic signed [`ADCC_IN_W-1:0] analogInput = '0;
    logic [`ADCC_W-1:0] sampleWord;
    logic sampleWordOe;
    logic rangeExceededFlag;
    logic dataValidClock;
    logic [`ADCC_W-1:0] capWord;
    logic capFlag;
    logic capOe;
    logic [15:0] capCount;
    // Scoreboard state.
    adcc_note_s sq[$];
    adcc_apb_s apbQ[$];
    adcc_note_s note;
    adcc_apb_s ans;
    int encCnt = 0;
    int cyc = 0;
    int nFail = 0;
    int nCompared = 0;
    logic clkChk = 1'b0;
    // Boundary samples: limits, one past them, zero and the extremes.
    logic signed [12:0] edgeVals [7] = '{13'sh03FF, 13'sh1C00, 13'sh0400, 13'sh1BFF, 13'sh0000, 13'sh0FFF, 13'sh1000};

    adcc_top i_adcc_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .encodeClockPos(encClk), .encodeClockNeg(~encClk), .analogInput(analogInput), .sampleWord(sampleWord),
        .sampleWordOe(sampleWordOe), .rangeExceededFlag(rangeExceededFlag), .dataValidClock(dataValidClock));
    adcc_capture_model i_adcc_capture_model (.dataValidClock(dataValidClock), .sampleWord(sampleWord),
        .sampleWordOe(sampleWordOe), .rangeExceededFlag(rangeExceededFlag), .capWord(capWord),
        .capFlag(capFlag), .capOe(capOe), .capCount(capCount));

    // Core clock at 100 ns.
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // Encode clock at 64 ns, offset so it has no phase tie to the core clock.
    initial begin
        #17;
        forever #32 encClk = ~encClk;
    end
    // Count encode rising edges; word due times are reckoned in these.
    always @(posedge encClk) encCnt <= encCnt + 1;

    // Expected flag and word, worked out from the input level and mode level.
    function automatic logic [`ADCC_W:0] expect_code(input logic signed [12:0] v, input logic [1:0] m);
        logic [`ADCC_W-1:0] c;
        logic f;
        f = (v > `ADCC_IN_MAX) || (v < `ADCC_IN_MIN);
        c = (v > `ADCC_IN_MAX) ? `ADCC_CODE_TOP : (v < `ADCC_IN_MIN) ? 11'h000 : 11'(v - `ADCC_IN_MIN);
        c[`ADCC_MSB] = c[`ADCC_MSB] ^ m[1];
        return {f, c};
    endfunction : expect_code

    // One APB transfer; the expected answer is noted before the request goes out.
    task automatic apb(input logic w, input logic [`ADCC_AW-1:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic [31:0] mk, input logic er);
        apbQ.push_back('{ex, mk, er});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Let n encode cycles pass, for settling after a mode change.
    task automatic settle(input int n);
        repeat (n) @(posedge encClk);
    endtask : settle

    // Feed n samples, boundaries first, and note each word with its due edge.
    task automatic stream(input int n, input logic [1:0] m);
        logic signed [12:0] v;
        clkChk = 1'b1;
        for (int i = 0; i < n; i++) begin
            v = (i < 7) ? edgeVals[i] : 13'($urandom_range(0, 2559)) - 13'h0500;
            @(posedge encClk);
            analogInput <= v;
            sq.push_back('{encCnt + 7, expect_code(v, m)});
        end
        settle(8);
        clkChk = 1'b0;
    endtask : stream

    // Print the verdict and end the run.
    task automatic tally_and_finish;
        `CHK("pending words", 0, sq.size())
        if (nFail == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Each latched word is matched with the oldest note that has fallen due.
    always @(capCount) begin
        if (sq.size() > 0 && sq[0].due <= encCnt) begin
            note = sq.pop_front();
            `CHK("word latency", note.due, encCnt)
            `CHK("word and flag", note.val, {capFlag, capWord})
            `CHK("output enable", 1'b1, capOe)
        end
    end

    // Each APB answer is matched with the oldest noted expectation.
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && apbQ.size() > 0) begin
            ans = apbQ.pop_front();
            `CHK("read data", ans.ex, prdata & ans.mk)
            `CHK("slave error", ans.er, pslverr)
        end
    end

    // The data-valid clock must still be low at a rising encode edge and high at a falling one.
    always @(encClk) begin
        if (clkChk) begin
            `CHK("data valid clock", ~encClk, dataValidClock)
        end
    end

    // A hang is cut short well past the expected run length.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            nFail++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        logic [31:0] seedVal;
        logic [31:0] ctrlVals [3];
        seedVal = $urandom(32'hDCF3B032);
        ctrlVals = '{32'h2, 32'h1, 32'h3};
        // Reset is held long enough to reach the encode domain.
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // Snapshots start as soon as the encode side leaves reset, so wait
        // until a zero input has filled the pipeline and reached the snapshot.
        settle(30);
        // Reset values, an unmapped place and a read-only register.
        apb(1'b0, `ADCC_CTRL_ADDR, '0, 32'h0, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, `ADCC_STATUS_ADDR, '0, 32'h0, 32'hFFFFFFFF, 1'b0);
        // A zero input reads back as mid-scale offset binary with no flag.
        apb(1'b0, `ADCC_SAMPLE_ADDR, '0, 32'h400, 32'hFFFFFFFF, 1'b0);
        // The snapshot count keeps moving, so only its unused bits are fixed.
        apb(1'b0, `ADCC_COUNT_ADDR, '0, 32'h0, 32'hFFFF0000, 1'b0);
        apb(1'b0, 12'h010, '0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, `ADCC_STATUS_ADDR, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `ADCC_STATUS_ADDR, '0, 32'h0, 32'h0000000F, 1'b0);
        // Every mode level in normal operation, with random upper control bits.
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `ADCC_CTRL_ADDR, ($urandom & 32'hFFFFFFF0) | 32'(m << 2), 32'h0, 32'h0, 1'b0);
            apb(1'b0, `ADCC_CTRL_ADDR, '0, 32'(m << 2), 32'hFFFFFFFF, 1'b0);
            apb(1'b0, `ADCC_STATUS_ADDR, '0, 32'({m[0] ^ m[1], m[1], 2'b00}), 32'h0000000F, 1'b0);
            settle(10);
            stream(24, 2'(m));
        end
        // Outputs off, nap and sleep; conversion must go on with outputs off.
        analogInput <= 13'sh1BFF;
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `ADCC_CTRL_ADDR, ctrlVals[k], 32'h0, 32'h0, 1'b0);
            apb(1'b0, `ADCC_STATUS_ADDR, '0, 32'(k + 1), 32'h00000003, 1'b0);
            settle(30);
            repeat (4) begin
                @(negedge encClk);
                `CHK("outputs released", 1'b0, sampleWordOe)
            end
            if (k == 0) begin
                apb(1'b0, `ADCC_SAMPLE_ADDR, '0, 32'h800, 32'hFFF, 1'b0);
                apb(1'b0, `ADCC_STATUS_ADDR, '0, 32'h11, 32'h1F, 1'b0);
            end
        end
        // Back to normal operation after sleep.
        apb(1'b1, `ADCC_CTRL_ADDR, 32'h0, 32'h0, 32'h0, 1'b0);
        settle(10);
        stream(12, 2'b00);
        tally_and_finish();
    end
endmodule : testbench
